/* logic/lsie_top.sv */
// Switch input evaluation and output function selection
module lsie_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire lsie_pkg::lsie_req_t bus_req,
  output lsie_pkg::lsie_rsp_t bus_rsp,
  input wire lsie_pkg::lsie_sw_t sw_pins,
  input wire logic power_stage_enabled,
  input wire logic reference_move_active,
  input wire logic warning_class0,
  input wire logic [3:0] pos_capture,
  input wire logic motor_moving_pos,
  input wire logic motor_moving_neg,
  output logic neg_limit_active,
  output logic pos_limit_active,
  output logic reference_active,
  output logic current_limit_active,
  output logic limit_enable_error,
  output logic function_output
);
  // Written (stored) selections
  logic [15:0] resp_q;
  logic [15:0] ref_pol_q;
  logic [15:0] neg_pol_q;
  logic [15:0] pos_pol_q;
  logic [15:0] cur_pol_q;
  logic [15:0] out_fn_q;
  // Selections in effect
  logic [15:0] ref_eff_q;
  logic [15:0] neg_eff_q;
  logic [15:0] pos_eff_q;
  logic [15:0] cur_eff_q;
  logic [15:0] out_fn_eff_q;
  logic ps_en_q;
  logic ps_rise_q;
  logic ps_rise;
  logic fn_loaded_q;
  lsie_pkg::lsie_sw_t sw_s;
  logic neg_d;
  logic pos_d;
  logic ref_d;
  logic cur_d;
  logic fn_d;
  logic wr_ok;
  logic wr_valid;
  logic hit;

  lsie_sync #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .din(sw_pins),
    .dout(sw_s)
  );

  assign ps_rise = power_stage_enabled && !ps_en_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ps_en_q <= 1'b0;
      ps_rise_q <= 1'b0;
    end else begin
      ps_en_q <= power_stage_enabled;
      ps_rise_q <= ps_rise;
    end
  end

  function automatic logic fn_code_ok(input logic [15:0] code);
    fn_code_ok = code == lsie_pkg::FN_SELECTED_WARNING
                 || (code >= lsie_pkg::FN_POS_REG_CH1 && code <= lsie_pkg::FN_MOVING_NEGATIVE);
  endfunction

  // Range check per offset
  always_comb begin
    hit = 1'b1;
    wr_valid = 1'b0;
    unique case (bus_req.addr)
      lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE:
        wr_valid = bus_req.wdata == lsie_pkg::RESP_ERROR || bus_req.wdata == lsie_pkg::RESP_NO_ERROR;
      lsie_pkg::OFS_REFERENCE_SWITCH_POLARITY,
      lsie_pkg::OFS_CURRENT_LIMIT_INPUT_POLARITY:
        wr_valid = bus_req.wdata == lsie_pkg::CODE_NC || bus_req.wdata == lsie_pkg::CODE_NO;
      lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY,
      lsie_pkg::OFS_POSITIVE_LIMIT_POLARITY:
        wr_valid = bus_req.wdata <= lsie_pkg::CODE_NO;
      lsie_pkg::OFS_OUTPUT_FUNCTION:
        wr_valid = fn_code_ok(bus_req.wdata);
      default: hit = 1'b0;
    endcase
  end

  // Response selection is writable any time; the rest only with power stage off
  assign wr_ok = bus_req.wr && hit && wr_valid
                 && (bus_req.addr == lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE || !power_stage_enabled);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resp_q <= lsie_pkg::RST_LIMIT_ENABLE_RESPONSE;
      ref_pol_q <= lsie_pkg::RST_REFERENCE_SWITCH_POLARITY;
      neg_pol_q <= lsie_pkg::RST_NEGATIVE_LIMIT_POLARITY;
      pos_pol_q <= lsie_pkg::RST_POSITIVE_LIMIT_POLARITY;
      cur_pol_q <= lsie_pkg::RST_CURRENT_LIMIT_INPUT_POLARITY;
    end else if (wr_ok) begin
      unique case (bus_req.addr)
        lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE: resp_q <= bus_req.wdata;
        lsie_pkg::OFS_REFERENCE_SWITCH_POLARITY: ref_pol_q <= bus_req.wdata;
        lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY: neg_pol_q <= bus_req.wdata;
        lsie_pkg::OFS_POSITIVE_LIMIT_POLARITY: pos_pol_q <= bus_req.wdata;
        lsie_pkg::OFS_CURRENT_LIMIT_INPUT_POLARITY: cur_pol_q <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // Persistent selection: no reset, so a power-up applies it instead of wiping it
  always_ff @(posedge mclk) begin
    if (wr_ok && bus_req.addr == lsie_pkg::OFS_OUTPUT_FUNCTION) begin
      out_fn_q <= bus_req.wdata;
    end
  end

  // Bus answer: one cycle after request; error on unmapped, bad code or locked
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_rsp <= '0;
    end else begin
      bus_rsp.ack <= bus_req.wr || bus_req.rd;
      bus_rsp.err <= (bus_req.wr && !wr_ok) || (bus_req.rd && !hit);
      bus_rsp.rdata <= 16'h0000;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE: bus_rsp.rdata <= resp_q;
          lsie_pkg::OFS_REFERENCE_SWITCH_POLARITY: bus_rsp.rdata <= ref_pol_q;
          lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY: bus_rsp.rdata <= neg_pol_q;
          lsie_pkg::OFS_POSITIVE_LIMIT_POLARITY: bus_rsp.rdata <= pos_pol_q;
          lsie_pkg::OFS_CURRENT_LIMIT_INPUT_POLARITY: bus_rsp.rdata <= cur_pol_q;
          lsie_pkg::OFS_OUTPUT_FUNCTION: bus_rsp.rdata <= out_fn_q;
          default: bus_rsp.rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Evaluation codes go live on the enable edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref_eff_q <= lsie_pkg::RST_REFERENCE_SWITCH_POLARITY;
      neg_eff_q <= lsie_pkg::RST_NEGATIVE_LIMIT_POLARITY;
      pos_eff_q <= lsie_pkg::RST_POSITIVE_LIMIT_POLARITY;
      cur_eff_q <= lsie_pkg::RST_CURRENT_LIMIT_INPUT_POLARITY;
    end else if (ps_rise) begin
      ref_eff_q <= ref_pol_q;
      neg_eff_q <= neg_pol_q;
      pos_eff_q <= pos_pol_q;
      cur_eff_q <= cur_pol_q;
    end
  end

  // Output function is taken once after reset, standing in for power-up
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_fn_eff_q <= lsie_pkg::RST_OUTPUT_FUNCTION;
      fn_loaded_q <= 1'b0;
    end else if (!fn_loaded_q) begin
      // Junk in the persistent word at first power-up falls back to the default
      if (fn_code_ok(out_fn_q)) begin
        out_fn_eff_q <= out_fn_q;
      end else begin
        out_fn_eff_q <= lsie_pkg::RST_OUTPUT_FUNCTION;
      end
      fn_loaded_q <= 1'b1;
    end
  end

  function automatic logic eval(input logic [15:0] code, input logic pin);
    unique case (code)
      lsie_pkg::CODE_NC: eval = !pin;
      lsie_pkg::CODE_NO: eval = pin;
      default: eval = 1'b0;
    endcase
  endfunction

  always_comb begin
    neg_d = eval(neg_eff_q, sw_s.neg_limit);
    pos_d = eval(pos_eff_q, sw_s.pos_limit);
    ref_d = reference_move_active && eval(ref_eff_q, sw_s.reference);
    cur_d = eval(cur_eff_q, sw_s.current_limit);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      neg_limit_active <= 1'b0;
      pos_limit_active <= 1'b0;
      reference_active <= 1'b0;
      current_limit_active <= 1'b0;
    end else begin
      neg_limit_active <= neg_d;
      pos_limit_active <= pos_d;
      reference_active <= ref_d;
      current_limit_active <= cur_d;
    end
  end

  // Checked one cycle after the enable edge, against freshly latched codes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      limit_enable_error <= 1'b0;
    end else if (!power_stage_enabled) begin
      limit_enable_error <= 1'b0;
    end else if (ps_rise_q && (neg_d || pos_d) && resp_q == lsie_pkg::RESP_ERROR) begin
      limit_enable_error <= 1'b1;
    end
  end

  always_comb begin
    unique case (out_fn_eff_q)
      lsie_pkg::FN_SELECTED_WARNING: fn_d = warning_class0;
      lsie_pkg::FN_POS_REG_CH1: fn_d = pos_capture[0];
      lsie_pkg::FN_POS_REG_CH2: fn_d = pos_capture[1];
      lsie_pkg::FN_POS_REG_CH3: fn_d = pos_capture[2];
      lsie_pkg::FN_POS_REG_CH4: fn_d = pos_capture[3];
      lsie_pkg::FN_MOVING_POSITIVE: fn_d = motor_moving_pos;
      lsie_pkg::FN_MOVING_NEGATIVE: fn_d = motor_moving_neg;
      default: fn_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      function_output <= 1'b0;
    end else begin
      function_output <= fn_d;
    end
  end

  AST_WARN_OUT: assert property (@(posedge mclk) disable iff (!resetn)
    out_fn_eff_q == lsie_pkg::FN_SELECTED_WARNING |=> function_output == $past(warning_class0))
    else $error("Warning output mismatch");
  AST_CAPTURE_OUT: assert property (@(posedge mclk) disable iff (!resetn)
    out_fn_eff_q == lsie_pkg::FN_POS_REG_CH3 |=> function_output == $past(pos_capture[2]))
    else $error("Capture channel output mismatch");
  AST_MOVE_NEG: assert property (@(posedge mclk) disable iff (!resetn)
    out_fn_eff_q == lsie_pkg::FN_MOVING_NEGATIVE |=> function_output == $past(motor_moving_neg))
    else $error("Negative motion output mismatch");
  AST_FN_FROZEN: assert property (@(posedge mclk) disable iff (!resetn)
    fn_loaded_q |=> $stable(out_fn_eff_q))
    else $error("Output function changed before power-up");
  AST_LOCKED: assert property (@(posedge mclk) disable iff (!resetn)
    power_stage_enabled && bus_req.wr && bus_req.addr == lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY
    |=> $stable(neg_pol_q))
    else $error("Selection written while power stage on");
  AST_LATCH: assert property (@(posedge mclk) disable iff (!resetn)
    !ps_rise |=> $stable(pos_eff_q))
    else $error("Evaluation code changed outside enable edge");
  AST_INACTIVE: assert property (@(posedge mclk) disable iff (!resetn)
    neg_eff_q == lsie_pkg::CODE_INACTIVE |=> !neg_limit_active)
    else $error("Ignored limit reported active");
  AST_REF_MASK: assert property (@(posedge mclk) disable iff (!resetn)
    !reference_move_active |=> !reference_active)
    else $error("Reference switch honoured outside reference movement");
  AST_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
    bus_req.wr && bus_req.addr == lsie_pkg::OFS_POSITIVE_LIMIT_POLARITY && bus_req.wdata > lsie_pkg::CODE_NO
    |=> $stable(pos_pol_q))
    else $error("Out-of-range code stored");
  AST_NO_ERR: assert property (@(posedge mclk) disable iff (!resetn)
    resp_q == lsie_pkg::RESP_NO_ERROR && !limit_enable_error |=> !limit_enable_error)
    else $error("Error raised with response selection 1");
  // Evaluation path
  AST_SYNC: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn, 2) |-> sw_s == $past(sw_pins, 2))
    else $error("Switch synchroniser latency wrong");
  AST_NEG_NC: assert property (@(posedge mclk) disable iff (!resetn)
    neg_eff_q == lsie_pkg::CODE_NC |=> neg_limit_active == !$past(sw_s.neg_limit))
    else $error("Normally-closed negative limit misread");
  AST_NEG_NO: assert property (@(posedge mclk) disable iff (!resetn)
    neg_eff_q == lsie_pkg::CODE_NO |=> neg_limit_active == $past(sw_s.neg_limit))
    else $error("Normally-open negative limit misread");
  AST_POS_NC: assert property (@(posedge mclk) disable iff (!resetn)
    pos_eff_q == lsie_pkg::CODE_NC |=> pos_limit_active == !$past(sw_s.pos_limit))
    else $error("Normally-closed positive limit misread");
  AST_POS_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    pos_eff_q == lsie_pkg::CODE_INACTIVE |=> !pos_limit_active)
    else $error("Ignored positive limit reported active");
  AST_CUR_NC: assert property (@(posedge mclk) disable iff (!resetn)
    cur_eff_q == lsie_pkg::CODE_NC |=> current_limit_active == !$past(sw_s.current_limit))
    else $error("Normally-closed current limit misread");
  AST_CUR_NO: assert property (@(posedge mclk) disable iff (!resetn)
    cur_eff_q == lsie_pkg::CODE_NO |=> current_limit_active == $past(sw_s.current_limit))
    else $error("Normally-open current limit misread");
  AST_REF_NC: assert property (@(posedge mclk) disable iff (!resetn)
    reference_move_active && ref_eff_q == lsie_pkg::CODE_NC
    |=> reference_active == !$past(sw_s.reference))
    else $error("Normally-closed reference switch misread");
  AST_REF_NO: assert property (@(posedge mclk) disable iff (!resetn)
    reference_move_active && ref_eff_q == lsie_pkg::CODE_NO
    |=> reference_active == $past(sw_s.reference))
    else $error("Normally-open reference switch misread");
  AST_EFF_LOAD: assert property (@(posedge mclk) disable iff (!resetn)
    ps_rise |=> neg_eff_q == $past(neg_pol_q))
    else $error("Stored code not taken at enable edge");
  AST_REF_HELD: assert property (@(posedge mclk) disable iff (!resetn)
    !ps_rise |=> $stable(ref_eff_q))
    else $error("Reference code changed outside enable edge");
  // Enable response and bus refusals
  AST_ERR_RAISE: assert property (@(posedge mclk) disable iff (!resetn)
    ps_rise_q && power_stage_enabled && resp_q == lsie_pkg::RESP_ERROR
    |=> limit_enable_error == (neg_limit_active || pos_limit_active))
    else $error("Enable error does not follow active limit");
  AST_ERR_CLEAR: assert property (@(posedge mclk) disable iff (!resetn)
    !power_stage_enabled |=> !limit_enable_error)
    else $error("Enable error kept with power stage off");
  AST_RESP_LIVE: assert property (@(posedge mclk) disable iff (!resetn)
    bus_req.wr && bus_req.addr == lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE
    && bus_req.wdata == lsie_pkg::RESP_NO_ERROR |=> resp_q == lsie_pkg::RESP_NO_ERROR)
    else $error("Response selection not applied at once");
  AST_REF_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
    bus_req.wr && bus_req.addr == lsie_pkg::OFS_REFERENCE_SWITCH_POLARITY
    && bus_req.wdata == lsie_pkg::CODE_INACTIVE |=> $stable(ref_pol_q))
    else $error("Illegal reference code stored");
  AST_LOCK_ERR: assert property (@(posedge mclk) disable iff (!resetn)
    power_stage_enabled && bus_req.wr && bus_req.addr != lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE
    |=> bus_rsp.err)
    else $error("Locked write not refused");
  // Output function routing
  AST_MOVE_POS: assert property (@(posedge mclk) disable iff (!resetn)
    out_fn_eff_q == lsie_pkg::FN_MOVING_POSITIVE |=> function_output == $past(motor_moving_pos))
    else $error("Positive motion output mismatch");
  AST_CAPTURE_CH1: assert property (@(posedge mclk) disable iff (!resetn)
    out_fn_eff_q == lsie_pkg::FN_POS_REG_CH1 |=> function_output == $past(pos_capture[0]))
    else $error("Capture channel 1 output mismatch");
  AST_CAPTURE_CH2: assert property (@(posedge mclk) disable iff (!resetn)
    out_fn_eff_q == lsie_pkg::FN_POS_REG_CH2 |=> function_output == $past(pos_capture[1]))
    else $error("Capture channel 2 output mismatch");
  AST_CAPTURE_CH4: assert property (@(posedge mclk) disable iff (!resetn)
    out_fn_eff_q == lsie_pkg::FN_POS_REG_CH4 |=> function_output == $past(pos_capture[3]))
    else $error("Capture channel 4 output mismatch");
endmodule // lsie_top

/* logic/lsie_pkg.sv */
// Package for the limit switch input evaluation block
package lsie_pkg;
  localparam logic [15:0] OFS_LIMIT_ENABLE_RESPONSE = 16'h060C;
  localparam logic [15:0] OFS_REFERENCE_SWITCH_POLARITY = 16'h061C;
  localparam logic [15:0] OFS_NEGATIVE_LIMIT_POLARITY = 16'h061E;
  localparam logic [15:0] OFS_POSITIVE_LIMIT_POLARITY = 16'h0620;
  localparam logic [15:0] OFS_CURRENT_LIMIT_INPUT_POLARITY = 16'h0850;
  localparam logic [15:0] OFS_OUTPUT_FUNCTION = 16'h0700;

  localparam logic [15:0] CODE_INACTIVE = 16'h0000;
  localparam logic [15:0] CODE_NC = 16'h0001;
  localparam logic [15:0] CODE_NO = 16'h0002;
  localparam logic [15:0] RESP_ERROR = 16'h0000;
  localparam logic [15:0] RESP_NO_ERROR = 16'h0001;

  localparam logic [15:0] RST_LIMIT_ENABLE_RESPONSE = 16'h0000;
  localparam logic [15:0] RST_REFERENCE_SWITCH_POLARITY = 16'h0001;
  localparam logic [15:0] RST_NEGATIVE_LIMIT_POLARITY = 16'h0001;
  localparam logic [15:0] RST_POSITIVE_LIMIT_POLARITY = 16'h0001;
  localparam logic [15:0] RST_CURRENT_LIMIT_INPUT_POLARITY = 16'h0002;
  localparam logic [15:0] RST_OUTPUT_FUNCTION = 16'h0010;

  localparam logic [15:0] FN_SELECTED_WARNING = 16'h0010;
  localparam logic [15:0] FN_POS_REG_CH1 = 16'h0012;
  localparam logic [15:0] FN_POS_REG_CH2 = 16'h0013;
  localparam logic [15:0] FN_POS_REG_CH3 = 16'h0014;
  localparam logic [15:0] FN_POS_REG_CH4 = 16'h0015;
  localparam logic [15:0] FN_MOVING_POSITIVE = 16'h0016;
  localparam logic [15:0] FN_MOVING_NEGATIVE = 16'h0017;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lsie_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } lsie_rsp_t;

  typedef struct packed {
    logic neg_limit;
    logic pos_limit;
    logic reference;
    logic current_limit;
  } lsie_sw_t;
endpackage

/* logic/lsie_sync.sv */
// Two-stage synchroniser, one per bit
module lsie_sync #(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        meta_q[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        meta_q[i] <= din[i];
        dout[i] <= meta_q[i];
      end
    end
  end
endmodule // lsie_sync

/* dv/lsie_axis_switches.sv */
// Model of the limit, reference and current-limit contacts on the machine axis
module lsie_axis_switches (
  input wire logic mclk,
  input wire lsie_pkg::lsie_sw_t closed_cmd,
  output lsie_pkg::lsie_sw_t sw_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle after the edge, never on it; high means contact closed
  initial sw_pins = '0;
  always @(posedge mclk) begin
    sw_pins <= #1 closed_cmd;
  end
endmodule // lsie_axis_switches

/* dv/testbench.sv */
// Self-checking bench for the switch evaluation block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic resetn;
  lsie_pkg::lsie_req_t bus_req;
  lsie_pkg::lsie_rsp_t bus_rsp;
  lsie_pkg::lsie_rsp_t r;
  lsie_pkg::lsie_sw_t sw_cmd;
  lsie_pkg::lsie_sw_t sw_pins;
  logic pse, rma, warn, moving_positive_output, moving_negative_output;
  logic [3:0] cap;
  logic neg_act, pos_act, ref_act, cur_act, en_err, fn_out;
  int n_mismatch;
  int checks;

  lsie_axis_switches sw (.mclk(mclk), .closed_cmd(sw_cmd), .sw_pins(sw_pins));
  lsie_top dut (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .bus_rsp(bus_rsp), .sw_pins(sw_pins),
    .power_stage_enabled(pse), .reference_move_active(rma), .warning_class0(warn), .pos_capture(cap),
    .motor_moving_pos(moving_positive_output), .motor_moving_neg(moving_negative_output), .neg_limit_active(neg_act),
    .pos_limit_active(pos_act), .reference_active(ref_act), .current_limit_active(cur_act),
    .limit_enable_error(en_err), .function_output(fn_out));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Strobe for one cycle; the answer stands in the cycle after it is taken
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    bus_req <= '0;
    #1 r = bus_rsp;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
    acc(1'b1, a, d);
    chk(r.ack, 16'h0001);
    chk(r.err, e);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(r.rdata, e);
  endtask

  task automatic set_stage(input logic v);
    @(posedge mclk);
    pse <= v;
    wt(6);
  endtask

  task automatic t_defaults;
    rd(lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE, 16'h0000);
    rd(lsie_pkg::OFS_REFERENCE_SWITCH_POLARITY, 16'h0001);
    rd(lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY, 16'h0001);
    rd(lsie_pkg::OFS_POSITIVE_LIMIT_POLARITY, 16'h0001);
    rd(lsie_pkg::OFS_CURRENT_LIMIT_INPUT_POLARITY, 16'h0002);
    rd(16'h0702, 16'h0000);
    chk(r.err, 16'h0001);
    chk({neg_act, pos_act, cur_act}, 16'h0006);
  endtask

  // New codes wait for the next enable of the power stage
  task automatic t_codes;
    wr(lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY, 16'h0002, 1'b0);
    wr(lsie_pkg::OFS_POSITIVE_LIMIT_POLARITY, 16'h0000, 1'b0);
    wr(lsie_pkg::OFS_CURRENT_LIMIT_INPUT_POLARITY, 16'h0001, 1'b0);
    wr(lsie_pkg::OFS_REFERENCE_SWITCH_POLARITY, 16'h0002, 1'b0);
    wr(lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE, 16'h0001, 1'b0);
    wr(lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY, 16'h0003, 1'b1);
    wr(lsie_pkg::OFS_REFERENCE_SWITCH_POLARITY, 16'h0000, 1'b1);
    rd(lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY, 16'h0002);
    wt(4);
    chk({neg_act, pos_act, cur_act}, 16'h0006);
    set_stage(1'b1);
    chk({neg_act, pos_act, cur_act}, 16'h0001);
    chk(en_err, 16'h0000);
    wr(lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY, 16'h0001, 1'b1);
    rd(lsie_pkg::OFS_NEGATIVE_LIMIT_POLARITY, 16'h0002);
    @(posedge mclk);
    sw_cmd <= '{neg_limit: 1'b1, pos_limit: 1'b1, reference: 1'b0, current_limit: 1'b1};
    wt(6);
    chk({neg_act, pos_act, cur_act}, 16'h0004);
    set_stage(1'b0);
  endtask

  // Negative limit held active across power stage enables
  task automatic t_response;
    wr(lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE, 16'h0002, 1'b1);
    wr(lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE, 16'h0000, 1'b0);
    set_stage(1'b1);
    chk(en_err, 16'h0001);
    wr(lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE, 16'h0001, 1'b0);
    rd(lsie_pkg::OFS_LIMIT_ENABLE_RESPONSE, 16'h0001);
    set_stage(1'b0);
    chk(en_err, 16'h0000);
    set_stage(1'b1);
    chk(en_err, 16'h0000);
    set_stage(1'b0);
  endtask

  task automatic t_reference;
    @(posedge mclk);
    sw_cmd.reference <= 1'b1;
    wt(6);
    chk(ref_act, 16'h0000);
    @(posedge mclk);
    rma <= 1'b1;
    wt(6);
    chk(ref_act, 16'h0001);
    @(posedge mclk);
    sw_cmd.reference <= 1'b0;
    wt(6);
    chk(ref_act, 16'h0000);
    rma <= 1'b0;
  endtask

  // Selector change is stored but the running function stays until power-up
  task automatic t_outfn;
    @(posedge mclk);
    warn <= 1'b1;
    wt(3);
    chk(fn_out, 16'h0001);
    wr(lsie_pkg::OFS_OUTPUT_FUNCTION, lsie_pkg::FN_MOVING_POSITIVE, 1'b0);
    wr(lsie_pkg::OFS_OUTPUT_FUNCTION, 16'h0011, 1'b1);
    rd(lsie_pkg::OFS_OUTPUT_FUNCTION, lsie_pkg::FN_MOVING_POSITIVE);
    @(posedge mclk);
    warn <= 1'b0;
    moving_positive_output <= 1'b1;
    wt(3);
    chk(fn_out, 16'h0000);
  endtask

  // Mid-run reset stands in for a power-up
  task automatic power_cycle;
    @(posedge mclk);
    resetn <= 1'b0;
    wt(2);
    resetn <= 1'b1;
    wt(6);
  endtask

  // Each stored selection from capture channel 1 to negative motion drives the output after the next power-up
  task automatic t_powerup;
    logic [15:0] fn;
    for (int i = 0; i < 6; i++) begin
      fn = lsie_pkg::FN_POS_REG_CH1 + 16'(i);
      wr(lsie_pkg::OFS_OUTPUT_FUNCTION, fn, 1'b0);
      power_cycle();
      @(posedge mclk);
      {moving_negative_output, moving_positive_output, cap} <= 6'h01 << i;
      wt(3);
      chk(fn_out, 16'h0001);
      @(posedge mclk);
      {moving_negative_output, moving_positive_output, cap} <= ~(6'h01 << i);
      wt(3);
      chk(fn_out, 16'h0000);
    end
    @(posedge mclk);
    rma <= 1'b1;
    wt(6);
    chk(ref_act, 16'h0001);
    chk({neg_act, pos_act, cur_act}, 16'h0001);
    rma <= 1'b0;
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    checks = 0;
    resetn = 1'b0;
    bus_req = '0;
    sw_cmd = '0;
    {pse, rma, warn, moving_positive_output, moving_negative_output} = '0;
    cap = 4'h0;
    wt(4);
    resetn <= 1'b1;
    wt(5);
    t_defaults();
    t_codes();
    t_response();
    t_reference();
    t_outfn();
    t_powerup();
    give_verdict();
  end

  initial begin
    #50000;
    n_mismatch++;
    give_verdict();
  end
endmodule // testbench
